// ### mcs_serial_regs.v
// Serial programming port and write-only control registers of the motor combo
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.vh"

module mcs_serial_regs (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        serial_frame_enable,
  input  wire        serial_clock,
  input  wire        serial_data_line_in,
  output reg         serial_data_line_out,
  output reg         serial_data_line_oe,
  output reg  [13:0] coil_current_code,
  output reg         coil_modulation_select,
  output reg         coil_cal_enable,
  output reg  [2:0]  sequencer_phase,
  output reg         sequencer_step,
  output reg         sequencer_restart,
  output reg         startup_internal,
  output reg         spindle_run,
  output reg         spindle_logic_reset_b,
  output reg         spindle_enable,
  output reg         speed_loop_cycle_select,
  output reg         spindle_chop_drive,
  output reg         loop_feedback_source,
  output reg         bemf_mask_short,
  output reg         on_time_sel_hi,
  output reg         on_time_sel_lo,
  output reg         pole_count_eight,
  output reg  [3:0]  commutation_delay,
  output reg  [11:0] speed_loop_coarse_count
);

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  wire enable_lvl;
  wire sclk_lvl;
  wire serial_data_line_lvl;

  mcs_sync #(.RESET_LEVEL(1'b0)) u_sync_enable (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_in    (serial_frame_enable),
    .level_out (enable_lvl)
  );

  mcs_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_in    (serial_clock),
    .level_out (sclk_lvl)
  );

  mcs_sync #(.RESET_LEVEL(1'b0)) u_sync_serial_data_line (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_in    (serial_data_line_in),
    .level_out (serial_data_line_lvl)
  );

  // ----------------------------------------------------------------
  // Serial clock edge detection
  // ----------------------------------------------------------------
  reg sclk_prev_reg;

  // Previous filtered clock level for edge finding
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_lvl;
    end
  end

  // Both edges come from filtered levels, so pin glitches shorter than the filter never count
  wire sclk_rise = sclk_lvl & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_lvl & sclk_prev_reg;

  // ----------------------------------------------------------------
  // Frame shifter and bit counter
  // ----------------------------------------------------------------
  reg  [15:0]               shift_reg;
  reg  [`MCS_CNT_W-1:0]     bit_cnt_reg;
  reg  [7:0]                rd_shift_reg;

  // Counter saturates at sixteen so extra clocks cannot disturb the frame
  wire shift_ok   = enable_lvl & sclk_rise & (bit_cnt_reg < `MCS_FRAME_BITS);
  // Each new bit enters at the top, so bit 0 of the frame ends in bit 0
  wire [15:0] frame_word = {serial_data_line_lvl, shift_reg[15:1]};
  // Commit only on the sixteenth rise inside one enable window
  wire frame_done = shift_ok & (bit_cnt_reg == `MCS_FRAME_LAST);
  wire frame_wr   = frame_done & ~frame_word[`MCS_RW_BIT];
  wire [6:0] wr_addr = frame_word[`MCS_ADDR_MSB:`MCS_ADDR_LSB];
  wire [7:0] wr_data = frame_word[`MCS_DATA_MSB:`MCS_DATA_LSB];

  // After eight shifts the command byte sits in the top half
  wire       rd_cmd  = shift_reg[`MCS_DATA_LSB];
  wire [6:0] rd_addr = shift_reg[15:9];

  // Dropping enable clears the count, which throws away a partial frame
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg   <= 16'h0000;
      bit_cnt_reg <= {`MCS_CNT_W{1'b0}};
    end else if (!enable_lvl) begin
      bit_cnt_reg <= {`MCS_CNT_W{1'b0}};
    end else if (shift_ok) begin
      shift_reg   <= frame_word;
      bit_cnt_reg <= bit_cnt_reg + 5'd1;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Offsets are whole command bytes; their upper seven bits are the address
  localparam [7:0] OFF_UPPER = `MCS_OFF_COIL_DAC_UPPER;
  localparam [7:0] OFF_LOWER = `MCS_OFF_COIL_DAC_LOWER;
  localparam [7:0] OFF_SPC   = `MCS_OFF_SPINDLE_CONTROL;
  localparam [7:0] OFF_SPT   = `MCS_OFF_SPINDLE_TIMING;
  localparam [7:0] OFF_CU    = `MCS_OFF_COARSE_UPPER;
  localparam [7:0] OFF_CF    = `MCS_OFF_COARSE_FINE;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [7:0] coil_dac_upper_reg;
  reg [7:0] coil_dac_lower_reg;
  reg [7:0] spindle_control_reg;
  reg [7:0] spindle_timing_reg;
  reg [7:0] speed_loop_coarse_upper_reg;
  reg [7:0] coarse_fine_reg;

  // Seven-bit compares on both sides, so no bits are padded or dropped
  wire hit_upper = (wr_addr == OFF_UPPER[7:1]);
  wire hit_lower = (wr_addr == OFF_LOWER[7:1]);
  wire hit_spc   = (wr_addr == OFF_SPC[7:1]);
  wire hit_spt   = (wr_addr == OFF_SPT[7:1]);
  wire hit_cu    = (wr_addr == OFF_CU[7:1]);
  wire hit_cf    = (wr_addr == OFF_CF[7:1]);

  // Writes to addresses outside this set simply fall through
  // The combined coarse/fine byte is kept whole; only its coarse nibble is used
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coil_dac_upper_reg          <= `MCS_RST_BYTE;
      coil_dac_lower_reg          <= `MCS_RST_BYTE;
      spindle_control_reg         <= `MCS_RST_BYTE;
      spindle_timing_reg          <= `MCS_RST_BYTE;
      speed_loop_coarse_upper_reg <= `MCS_RST_BYTE;
      coarse_fine_reg             <= `MCS_RST_BYTE;
    end else if (frame_wr) begin
      if (hit_upper) begin
        coil_dac_upper_reg <= wr_data;
      end
      if (hit_lower) begin
        coil_dac_lower_reg <= wr_data;
      end
      if (hit_spc) begin
        spindle_control_reg <= wr_data;
      end
      if (hit_spt) begin
        spindle_timing_reg <= wr_data;
      end
      if (hit_cu) begin
        speed_loop_coarse_upper_reg <= wr_data;
      end
      if (hit_cf) begin
        coarse_fine_reg <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read-back selection
  // ----------------------------------------------------------------
  // The map is write-only; echoing the stored byte is a harmless choice
  function [7:0] read_select;
    input [6:0] a;
    begin
      if (a == OFF_UPPER[7:1]) begin
        read_select = coil_dac_upper_reg;
      end else if (a == OFF_LOWER[7:1]) begin
        read_select = coil_dac_lower_reg;
      end else if (a == OFF_SPC[7:1]) begin
        read_select = spindle_control_reg;
      end else if (a == OFF_SPT[7:1]) begin
        read_select = spindle_timing_reg;
      end else if (a == OFF_CU[7:1]) begin
        read_select = speed_loop_coarse_upper_reg;
      end else if (a == OFF_CF[7:1]) begin
        read_select = coarse_fine_reg;
      end else begin
        read_select = `MCS_UNDEF_READ;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Read data driver
  // ----------------------------------------------------------------
  // Address comes from the command byte held after the eighth rise
  wire [7:0] rd_byte  = read_select(rd_addr);
  wire       rd_start = enable_lvl & sclk_fall & (bit_cnt_reg == `MCS_CMD_BITS) & rd_cmd;
  // Bits D0..D6 are replaced after rises nine to fifteen; D7 stands
  wire       rd_next  = enable_lvl & sclk_rise & serial_data_line_oe &
                        (bit_cnt_reg >= `MCS_CMD_BITS) & (bit_cnt_reg < `MCS_FRAME_LAST);

  // Line is released as soon as enable goes away
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe  <= 1'b0;
      rd_shift_reg         <= 8'h00;
    end else if (!enable_lvl) begin
      serial_data_line_oe  <= 1'b0;
      serial_data_line_out <= 1'b0;
    end else if (rd_start) begin
      serial_data_line_oe  <= 1'b1;
      serial_data_line_out <= rd_byte[0];
      rd_shift_reg         <= {1'b0, rd_byte[7:1]};
    end else if (rd_next) begin
      serial_data_line_out <= rd_shift_reg[0];
      rd_shift_reg         <= {1'b0, rd_shift_reg[7:1]};
    end
  end

  // ----------------------------------------------------------------
  // Coil DAC outputs
  // ----------------------------------------------------------------
  // The upper byte waits in its register until the lower byte lands,
  // so the coil never sees a half-updated code
  wire apply_dac = frame_wr & hit_lower;

  // Magnitude, modulation and calibration bits all switch at one clock edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coil_current_code      <= 14'h0000;
      coil_modulation_select <= 1'b0;
      coil_cal_enable        <= 1'b0;
    end else if (apply_dac) begin
      coil_current_code      <= {coil_dac_upper_reg[`MCS_DACU_MAG_MSB:0], wr_data};
      coil_modulation_select <= coil_dac_upper_reg[`MCS_DACU_MOD_BIT];
      coil_cal_enable        <= coil_dac_upper_reg[`MCS_DACU_CAL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Commutation sequencer
  // ----------------------------------------------------------------
  // Step only on a 0 to 1 change against the previously stored bit
  wire step_edge = frame_wr & hit_spc & wr_data[`MCS_SPC_STEP_BIT] &
                   ~spindle_control_reg[`MCS_SPC_STEP_BIT];
  wire restart_wr = frame_wr & hit_spc & wr_data[`MCS_SPC_RESTART_BIT];

  // Restart outranks a step arriving in the same frame
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sequencer_phase <= `MCS_SEQ_FIRST;
      sequencer_step  <= 1'b0;
    end else begin
      sequencer_step <= step_edge;
      if (restart_wr) begin
        sequencer_phase <= `MCS_SEQ_FIRST;
      end else if (step_edge) begin
        // Six phases, wrapping from the last back to the first
        if (sequencer_phase == `MCS_SEQ_LAST) begin
          sequencer_phase <= `MCS_SEQ_FIRST;
        end else begin
          sequencer_phase <= sequencer_phase + 3'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Spindle control and timing outputs
  // ----------------------------------------------------------------
  // Registered copies so every output comes straight from a flip-flop
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sequencer_restart       <= 1'b0;
      startup_internal        <= 1'b0;
      spindle_run             <= 1'b0;
      spindle_logic_reset_b   <= 1'b0;
      spindle_enable          <= 1'b0;
      speed_loop_cycle_select <= 1'b0;
      spindle_chop_drive      <= 1'b0;
      loop_feedback_source    <= 1'b0;
      bemf_mask_short         <= 1'b0;
      on_time_sel_hi          <= 1'b0;
      on_time_sel_lo          <= 1'b0;
      pole_count_eight        <= 1'b0;
      commutation_delay       <= 4'h0;
      speed_loop_coarse_count <= 12'h000;
    end else begin
      sequencer_restart       <= spindle_control_reg[`MCS_SPC_RESTART_BIT];
      startup_internal        <= spindle_control_reg[`MCS_SPC_START_BIT];
      spindle_run             <= spindle_control_reg[`MCS_SPC_RUN_BIT];
      spindle_logic_reset_b   <= spindle_control_reg[`MCS_SPC_RUN_BIT];
      spindle_enable          <= spindle_control_reg[`MCS_SPC_EN_BIT];
      speed_loop_cycle_select <= spindle_control_reg[`MCS_SPC_CYCLE_BIT];
      spindle_chop_drive      <= spindle_control_reg[`MCS_SPC_CHOP_BIT];
      loop_feedback_source    <= spindle_control_reg[`MCS_SPC_FBK_BIT];
      bemf_mask_short         <= spindle_timing_reg[`MCS_SPT_MASK_BIT];
      on_time_sel_hi          <= spindle_timing_reg[`MCS_SPT_ONHI_BIT];
      on_time_sel_lo          <= spindle_timing_reg[`MCS_SPT_ONLO_BIT];
      pole_count_eight        <= spindle_timing_reg[`MCS_SPT_POLE_BIT];
      // The delay field is stored MSB in bit 4 down to LSB in bit 7
      commutation_delay       <= {spindle_timing_reg[4], spindle_timing_reg[5],
                                  spindle_timing_reg[6], spindle_timing_reg[7]};
      speed_loop_coarse_count <= {speed_loop_coarse_upper_reg,
                                  coarse_fine_reg[`MCS_CF_COARSE_MSB:`MCS_CF_COARSE_LSB]};
    end
  end

endmodule // mcs_serial_regs

`default_nettype wire

// ### mcs_defs.vh
// Constants for the motor combo serial register port
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define MCS_FRAME_BITS      5'd16
`define MCS_FRAME_LAST      5'd15
`define MCS_CMD_BITS        5'd8
`define MCS_CNT_W           5
`define MCS_RW_BIT          0
`define MCS_ADDR_LSB        1
`define MCS_ADDR_MSB        7
`define MCS_DATA_LSB        8
`define MCS_DATA_MSB        15

// ----------------------------------------------------------------
// Register offsets, printed as write command bytes with the R/W bit clear
// ----------------------------------------------------------------
`define MCS_OFF_COIL_DAC_UPPER   8'h0e
`define MCS_OFF_COIL_DAC_LOWER   8'h1e
`define MCS_OFF_SPINDLE_CONTROL  8'h2e
`define MCS_OFF_SPINDLE_TIMING   8'h3e
`define MCS_OFF_COARSE_UPPER     8'h4e
`define MCS_OFF_COARSE_FINE      8'h5e

// ----------------------------------------------------------------
// Reset value and unmapped read value
// ----------------------------------------------------------------
`define MCS_RST_BYTE        8'h00
`define MCS_UNDEF_READ      8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCS_DACU_MAG_MSB    5
`define MCS_DACU_MOD_BIT    6
`define MCS_DACU_CAL_BIT    7
`define MCS_SPC_STEP_BIT    0
`define MCS_SPC_START_BIT   1
`define MCS_SPC_RESTART_BIT 2
`define MCS_SPC_RUN_BIT     3
`define MCS_SPC_EN_BIT      4
`define MCS_SPC_CYCLE_BIT   5
`define MCS_SPC_CHOP_BIT    6
`define MCS_SPC_FBK_BIT     7
`define MCS_SPT_MASK_BIT    0
`define MCS_SPT_ONLO_BIT    1
`define MCS_SPT_ONHI_BIT    2
`define MCS_SPT_POLE_BIT    3
`define MCS_SPT_DLY_MSB_BIT 4
`define MCS_SPT_DLY_LSB_BIT 7
`define MCS_CF_COARSE_LSB   4
`define MCS_CF_COARSE_MSB   7

// ----------------------------------------------------------------
// Commutation sequencer
// ----------------------------------------------------------------
`define MCS_SEQ_W           3
`define MCS_SEQ_FIRST       3'd0
`define MCS_SEQ_LAST        3'd5

`endif

// ### mcs_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module mcs_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  input  wire clk,
  input  wire rst_b,
  input  wire pin_in,
  output reg  level_out
);

  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // Stage one feeds only stage two; the filter looks at two and three
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
      stage3_reg <= RESET_LEVEL;
      level_out  <= RESET_LEVEL;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (stage2_reg == stage3_reg) begin
        level_out <= stage3_reg;
      end
    end
  end

endmodule // mcs_sync

`default_nettype wire

// ### mcs_unused_guard.v
// Spare source file; it holds no logic

// ### mcs_serial_regs_sva.sv
// Checker for the motor combo serial register port
`timescale 1ns/1ps
`default_nettype none
module mcs_serial_regs_sva (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        serial_frame_enable,
  input wire logic        serial_clock,
  input wire logic        serial_data_line_out,
  input wire logic        serial_data_line_oe,
  input wire logic [13:0] coil_current_code,
  input wire logic [2:0]  sequencer_phase,
  input wire logic        sequencer_step,
  input wire logic        sequencer_restart,
  input wire logic        spindle_run,
  input wire logic        spindle_logic_reset_b,
  input wire logic [11:0] speed_loop_coarse_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Read path on the shared data line
  // ----------------------------------------------------------------
  AST_OE_IDLE: assert property (!serial_frame_enable [*8] |-> !serial_data_line_oe)
    else $error("data line driven outside a frame");
  AST_OUT_QUIET: assert property (!serial_data_line_oe [*2] |-> !serial_data_line_out)
    else $error("data output not parked while released");
  AST_OE_RISE: assert property ($rose(serial_data_line_oe) |-> !serial_clock && serial_frame_enable)
    else $error("read drive began away from a clock low phase");
  // Bits move only in the high phase that follows a serial clock rise
  AST_SHIFT_EDGE: assert property (serial_data_line_oe && $past(serial_data_line_oe)
    && $changed(serial_data_line_out) |-> serial_clock && $past(serial_clock, 3))
    else $error("read bit changed outside a clock high phase");
  // ----------------------------------------------------------------
  // Register outputs
  // ----------------------------------------------------------------
  // Once the frame is closed the coil code, coarse count and phase may not move, aborted frames included
  AST_HOLD: assert property (!serial_frame_enable [*8] |=> $stable(coil_current_code)
    && $stable(speed_loop_coarse_count) && $stable(sequencer_phase))
    else $error("outputs moved with no frame open");
  AST_STEP_PULSE: assert property (sequencer_step |=> !sequencer_step)
    else $error("step pulse longer than one cycle");
  AST_PHASE_RANGE: assert property (sequencer_phase <= 3'd5)
    else $error("sequencer phase out of range");
  // The restart copy lags the phase by one cycle, so look at the phase one cycle back
  AST_RESTART: assert property (sequencer_restart |-> $past(sequencer_phase) == 3'd0)
    else $error("sequencer not held at first phase");
  // Only a step can move the phase anywhere but the first phase
  AST_STEP_MOVES: assert property ($changed(sequencer_phase) && sequencer_phase != 3'd0 |-> sequencer_step)
    else $error("sequencer phase moved without a step pulse");
  AST_RUN_RESET: assert property (spindle_logic_reset_b == spindle_run)
    else $error("spindle logic reset does not follow run");
  COV_READ: cover property ($rose(serial_data_line_oe));
  COV_STEP: cover property (sequencer_step);
  COV_COIL: cover property ($changed(coil_current_code));
endmodule // mcs_serial_regs_sva

bind mcs_serial_regs mcs_serial_regs_sva u_sva (.clk, .rst_b, .serial_frame_enable,
  .serial_clock, .serial_data_line_out, .serial_data_line_oe, .coil_current_code,
  .sequencer_phase, .sequencer_step, .sequencer_restart, .spindle_run,
  .spindle_logic_reset_b, .speed_loop_coarse_count);
`default_nettype wire

// ### mcs_host_model.sv
// Host processor model driving the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module mcs_host_model (
  input  wire logic clk,
  input  wire logic serial_data_line_out,
  input  wire logic serial_data_line_oe,
  output var  logic serial_frame_enable,
  output var  logic serial_clock,
  output wire logic serial_data_line_in
);
  logic drv_d    = 1'b0;
  logic drv_oe   = 1'b0;
  logic last_lvl = 1'b0;
  // No pull on the line: a released line shows the inverse of its last level
  assign serial_data_line_in = serial_data_line_oe ? serial_data_line_out :
                               drv_oe ? drv_d : ~last_lvl;
  always @(posedge clk) last_lvl <= serial_data_line_in;
  initial begin
    serial_frame_enable = 1'b0;
    serial_clock = 1'b0;
  end
  // One frame of n pulses, 160 ns period; pulses past 16 carry inverted bits
  task automatic frame(input logic [15:0] b, input int n, output logic [7:0] r);
    int i;
    r = 8'h00;
    @(posedge clk);
    serial_frame_enable <= 1'b1;
    drv_oe <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < n; i++) begin
      serial_clock <= 1'b0;
      drv_d <= (i < 16) ? b[i] : ~b[i - 16];
      drv_oe <= !(b[0] && i >= 8);
      repeat (8) @(posedge clk);
      if (i >= 8 && i < 16) r[i - 8] = serial_data_line_in;
      serial_clock <= 1'b1;
      repeat (8) @(posedge clk);
    end
    serial_clock <= 1'b0;
    repeat (4) @(posedge clk);
    serial_frame_enable <= 1'b0;
    drv_oe <= 1'b0;
  endtask
endmodule // mcs_host_model
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the motor combo serial register port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst_b, serial_frame_enable, serial_clock, serial_data_line_in;
  logic        serial_data_line_out, serial_data_line_oe, coil_modulation_select;
  logic        coil_cal_enable, sequencer_step, sequencer_restart, startup_internal;
  logic        spindle_run, spindle_logic_reset_b, spindle_enable, speed_loop_cycle_select;
  logic        spindle_chop_drive, loop_feedback_source, bemf_mask_short, on_time_sel_hi;
  logic        on_time_sel_lo, pole_count_eight;
  logic [13:0] coil_current_code;
  logic [2:0]  sequencer_phase, ph_exp;
  logic [3:0]  commutation_delay;
  logic [11:0] speed_loop_coarse_count;
  logic [7:0]  regs [0:127];
  logic [7:0]  coil_hi_app, rd_byte, rd_exp, rv;
  logic [31:0] rng;
  logic [54:0] exp_q [$];
  string       nm_q [$];
  int          miscompares, num_checks, k;
  event        chk_ev;
  wire  [46:0] obs = {coil_current_code, coil_modulation_select, coil_cal_enable,
    sequencer_restart, startup_internal, spindle_run, spindle_logic_reset_b, spindle_enable,
    speed_loop_cycle_select, spindle_chop_drive, loop_feedback_source, bemf_mask_short,
    on_time_sel_hi, on_time_sel_lo, pole_count_eight, commutation_delay,
    speed_loop_coarse_count, sequencer_phase};

  mcs_serial_regs u_dut (.clk, .rst_b, .serial_frame_enable, .serial_clock,
    .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe, .coil_current_code,
    .coil_modulation_select, .coil_cal_enable, .sequencer_phase, .sequencer_step,
    .sequencer_restart, .startup_internal, .spindle_run, .spindle_logic_reset_b,
    .spindle_enable, .speed_loop_cycle_select, .spindle_chop_drive, .loop_feedback_source,
    .bemf_mask_short, .on_time_sel_hi, .on_time_sel_lo, .pole_count_eight,
    .commutation_delay, .speed_loop_coarse_count);
  mcs_host_model u_host (.clk, .serial_data_line_out, .serial_data_line_oe,
    .serial_frame_enable, .serial_clock, .serial_data_line_in);

  // Fixed-seed xorshift source for data bytes
  function automatic logic [7:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  // Output image expected from the register mirror
  function automatic logic [46:0] exp_vec();
    logic [7:0] c, t;
    c = regs[23];
    t = regs[31];
    return {coil_hi_app[5:0], regs[15], coil_hi_app[6], coil_hi_app[7],
      c[2], c[1], c[3], c[3], c[4], c[5], c[6], c[7],
      t[0], t[2], t[1], t[3], t[4], t[5], t[6], t[7],
      regs[39], regs[47][7:4], ph_exp};
  endfunction
  task automatic check(input string nm, input logic [54:0] s, input logic [54:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic note(input string nm);
    exp_q.push_back({exp_vec(), rd_exp});
    nm_q.push_back(nm);
    -> chk_ev;
  endtask
  // One frame, mirror update, then a note once the outputs have settled
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] d, input int n, input string nm);
    logic [7:0] r;
    logic [6:0] a;
    a = cmd[7:1];
    u_host.frame({d, cmd}, n, r);
    if (n >= 16 && cmd[0]) begin
      rd_byte = r;
      rd_exp = regs[a];
    end else if (n >= 16 && a[2:0] == 3'b111 && a[6:3] < 4'd6) begin
      if (a == 7'd23 && d[2]) ph_exp = 3'd0;
      else if (a == 7'd23 && d[0] && !regs[23][0]) ph_exp = (ph_exp == 3'd5) ? 3'd0 : ph_exp + 3'd1;
      if (a == 7'd15) coil_hi_app = regs[7];
      regs[a] = d;
    end
    repeat (12) @(posedge clk);
    note(nm);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) regs[i] = 8'h00;
    coil_hi_app = 8'h00;
    ph_exp = 3'd0;
    repeat (4) @(posedge clk);
    note("reset");
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Every note is compared against the settled outputs and last read byte
  initial forever begin
    @(chk_ev);
    check(nm_q.pop_front(), {obs, rd_byte}, exp_q.pop_front());
  end
  // Whole run is about 16k cycles; the limit leaves over three times that
  initial begin
    #600000;
    miscompares++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    rng = 32'hb09402b1;
    miscompares = 0;
    num_checks = 0;
    rd_byte = 8'h00;
    rd_exp = 8'h00;
    @(posedge clk);
    do_reset();
    for (k = 0; k < 6; k++) begin
      xfer({k[3:0], 4'he}, xs(), 16, "wr");
      xfer({k[3:0], 4'hf}, 8'h00, 16, "rd");
    end
    done("map");
    xfer(8'h0e, xs(), 16, "hi_pending");
    xfer(8'h1e, xs(), 16, "lo_apply");
    xfer(8'h2e, xs(), 10, "abort");
    xfer(8'h4e, xs(), 20, "overrun");
    xfer(8'h7e, xs(), 16, "unmapped");
    xfer(8'h7f, 8'h00, 16, "unmapped_rd");
    done("frame");
    // Toggle the step bit past a wrap, with one restart landing on a step
    for (k = 0; k < 16; k++) begin
      rv = (xs() & 8'hfa) | {7'd0, k[0]} | (k == 13 ? 8'h04 : 8'h00);
      xfer(8'h2e, rv, 16, "seq");
    end
    done("sequencer");
    for (k = 0; k < 24; k++) begin
      rv = xs();
      xfer({rv[7:4] % 4'd6, 3'b111, rv[0]}, xs(), 16, "mix");
    end
    done("mix");
    do_reset();
    xfer(8'h3f, 8'h00, 16, "rd_after_reset");
    done("reset");
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
